/* File: verilog/i2c_xfer_regs.svh */
// Constants for the I2C bit-level transfer engine
`ifndef I2C_XFER_REGS_SVH
`define I2C_XFER_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define I2C_CLK_PERIOD_NS 5
`define I2C_HALF_NS 5000
`define I2C_HALF_CYC ((`I2C_HALF_NS + `I2C_CLK_PERIOD_NS - 1) / `I2C_CLK_PERIOD_NS)
`define I2C_CNT_W 11

// ----------------------------------------
// Byte framing
// ----------------------------------------
`define I2C_LAST_DATA_BIT 4'h7
`define I2C_ACK_BIT 4'h8
`define I2C_RELEASE_BYTE 8'hFF
`define I2C_BYTE_RESET 8'hFF

`endif

/* File: verilog/i2c_xfer_pkg.sv */
// Types for the I2C bit-level transfer engine
package i2c_xfer_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START_HOLD,
		ST_BYTE,
		ST_HOLD_WAIT,
		ST_STOP_LOW,
		ST_STOP_HIGH
	} xfer_state_t;

endpackage

/* File: verilog/i2c_line_sync.sv */
// Bus line synchroniser with edge and condition detection
`timescale 1ns/1ps
module i2c_line_sync (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Raw bus levels
	input wire logic scl_in,
	input wire logic sda_in,
	// Synchronised levels and events
	output logic scl_s,
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det
);

	logic scl_meta;
	logic sda_meta;
	logic scl_d;
	logic sda_d;

	// ----------------------------------------
	// Two-stage synchronisers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			scl_meta <= 1'b1;
			sda_meta <= 1'b1;
			scl_s <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			scl_meta <= scl_in;
			sda_meta <= sda_in;
			scl_s <= scl_meta;
			sda_s <= sda_meta;
		end
	end

	// ----------------------------------------
	// Delayed copies for edges
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_det = scl_s && scl_d && sda_d && !sda_s;
	assign stop_det = scl_s && scl_d && !sda_d && sda_s;

endmodule

/* File: verilog/i2c_xfer_timing.sv */
// I2C bit-level data transfer engine with 9-clock wait
`timescale 1ns/1ps
`include "i2c_xfer_regs.svh"

// Summary of operation
// - Master opens each transfer by sending the slave address on the bus.
// - Direction bit follows the address directly, then data transfer starts.
// - Shift data register shifts on each SCL falling edge that ends a data bit, presenting a new bit.
// - Transmit bits go from register via output latch onto SDA, MSB first.
// - SDA bits are sampled toward the shift data register on SCL rising edges.
// - Writing all-ones or setting wait release ends the receiving side wait.
// - Master wait while reading ends on all-ones write or wait release.
module i2c_xfer_timing
	import i2c_xfer_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// CPU side
	input wire logic master_en,
	input wire logic wait_sel9,
	input wire logic ack_en,
	input wire logic [6:0] own_addr,
	input wire logic [6:0] slave_addr,
	input wire logic transfer_direction_bit,
	input wire logic start_req,
	input wire logic stop_req,
	input wire logic wr_stb,
	input wire logic [7:0] wr_data,
	input wire logic wait_release_bit,
	// CPU status
	output logic [7:0] shift_data_reg,
	output logic byte_done,
	output logic in_wait,
	output logic ack_seen,
	output logic busy,
	output logic is_tx,
	output logic is_master,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe
);

	xfer_state_t st;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [`I2C_CNT_W-1:0] cnt;
	logic [3:0] bit_cnt;
	logic fresh;
	logic rx_bit;
	logic addr_phase;
	logic dir_rd;
	logic go_start;
	logic release_wait;
	logic half_done;
	logic [7:0] next_shift;

	i2c_line_sync u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);

	assign go_start = (st == ST_IDLE) && master_en && start_req && !busy;
	assign release_wait = (st == ST_HOLD_WAIT) && (wr_stb || wait_release_bit) &&
		!(is_master && stop_req);
	assign half_done = (cnt == `I2C_CNT_W'(`I2C_HALF_CYC - 1));
	assign next_shift = {shift_data_reg[6:0], rx_bit};

	// ----------------------------------------
	// Bus busy between start and stop
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			busy <= 1'b0;
		end else if (stop_det) begin
			busy <= 1'b0;
		end else if (start_det) begin
			busy <= 1'b1;
		end
	end

	// ----------------------------------------
	// Sequencer and SCL drive
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st <= ST_IDLE;
			cnt <= '0;
			scl_oe <= 1'b0;
			is_master <= 1'b0;
		end else begin
			case (st)
				ST_IDLE: begin
					cnt <= '0;
					scl_oe <= 1'b0;
					if (go_start) begin
						is_master <= 1'b1;
						st <= ST_START_HOLD;
					end else if (start_det) begin
						is_master <= 1'b0;
						st <= ST_BYTE;
					end
				end
				ST_START_HOLD: begin
					cnt <= half_done ? '0 : cnt + 1'b1;
					if (half_done) begin
						scl_oe <= 1'b1;
						st <= ST_BYTE;
					end
				end
				ST_BYTE: begin
					if (!is_master && stop_det) begin
						st <= ST_IDLE;
					end else if (scl_fall && bit_cnt == `I2C_ACK_BIT && !fresh && wait_sel9) begin
						scl_oe <= 1'b1;
						cnt <= '0;
						st <= ST_HOLD_WAIT;
					end else if (!is_master && scl_fall && addr_phase && !fresh &&
						bit_cnt == `I2C_LAST_DATA_BIT && next_shift[7:1] != own_addr) begin
						st <= ST_IDLE;
					end else if (is_master) begin
						if (scl_oe) begin
							cnt <= half_done ? '0 : cnt + 1'b1;
							scl_oe <= !half_done;
						end else if (scl_s) begin
							cnt <= half_done ? '0 : cnt + 1'b1;
							scl_oe <= half_done;
						end
					end
				end
				ST_HOLD_WAIT: begin
					cnt <= '0;
					if (!is_master && stop_det) begin
						scl_oe <= 1'b0;
						st <= ST_IDLE;
					end else if (is_master && stop_req) begin
						st <= ST_STOP_LOW;
					end else if (release_wait) begin
						scl_oe <= is_master;
						st <= ST_BYTE;
					end
				end
				ST_STOP_LOW: begin
					cnt <= half_done ? '0 : cnt + 1'b1;
					if (half_done) begin
						scl_oe <= 1'b0;
						st <= ST_STOP_HIGH;
					end
				end
				ST_STOP_HIGH: begin
					if (scl_s) begin
						cnt <= half_done ? '0 : cnt + 1'b1;
						if (half_done) begin
							is_master <= 1'b0;
							st <= ST_IDLE;
						end
					end
				end
				default: begin
					st <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Rising edge sampling
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rx_bit <= 1'b1;
			ack_seen <= 1'b0;
		end else if (st == ST_BYTE && scl_rise) begin
			rx_bit <= sda_s;
			if (bit_cnt == `I2C_ACK_BIT) begin
				ack_seen <= !sda_s;
			end
		end
	end

	// ----------------------------------------
	// Shift register, bit count, output latch
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			shift_data_reg <= `I2C_BYTE_RESET;
			bit_cnt <= '0;
			fresh <= 1'b0;
			addr_phase <= 1'b0;
			dir_rd <= 1'b0;
			is_tx <= 1'b0;
			sda_oe <= 1'b0;
			byte_done <= 1'b0;
		end else begin
			byte_done <= 1'b0;
			if (go_start) begin
				shift_data_reg <= {slave_addr, transfer_direction_bit};
				dir_rd <= transfer_direction_bit;
				is_tx <= 1'b1;
				addr_phase <= 1'b1;
				fresh <= 1'b1;
				bit_cnt <= '0;
				sda_oe <= 1'b1;
			end else if (st == ST_IDLE && start_det) begin
				is_tx <= 1'b0;
				addr_phase <= 1'b1;
				fresh <= 1'b1;
				bit_cnt <= '0;
				sda_oe <= 1'b0;
			end else if (st == ST_IDLE || (!is_master && stop_det)) begin
				sda_oe <= 1'b0;
			end else if (st == ST_HOLD_WAIT && is_master && stop_req) begin
				sda_oe <= 1'b1;
			end else if (st == ST_STOP_HIGH && scl_s && half_done) begin
				sda_oe <= 1'b0;
			end else if (release_wait) begin
				if (wr_stb) begin
					shift_data_reg <= wr_data;
				end
				bit_cnt <= '0;
				sda_oe <= is_tx && !(wr_stb ? wr_data[7] : shift_data_reg[7]);
			end else if (st == ST_BYTE && scl_fall) begin
				if (fresh) begin
					fresh <= 1'b0;
					sda_oe <= is_tx && !shift_data_reg[7];
				end else if (bit_cnt < `I2C_LAST_DATA_BIT) begin
					shift_data_reg <= next_shift;
					sda_oe <= is_tx && !shift_data_reg[6];
					bit_cnt <= bit_cnt + 1'b1;
				end else if (bit_cnt == `I2C_LAST_DATA_BIT) begin
					shift_data_reg <= next_shift;
					bit_cnt <= `I2C_ACK_BIT;
					if (addr_phase) begin
						sda_oe <= !is_master;
					end else begin
						sda_oe <= !is_tx && ack_en;
					end
					if (addr_phase && !is_master) begin
						dir_rd <= next_shift[0];
					end
				end else begin
					byte_done <= 1'b1;
					addr_phase <= 1'b0;
					bit_cnt <= '0;
					if (addr_phase) begin
						is_tx <= is_master ? !dir_rd : dir_rd;
					end
					if (wait_sel9) begin
						sda_oe <= 1'b0;
					end else begin
						sda_oe <= !shift_data_reg[7] &&
							(addr_phase ? (is_master ? !dir_rd : dir_rd) : is_tx);
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Open-drain levels and wait flag
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			in_wait <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			in_wait <= (st == ST_HOLD_WAIT);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_addr_load: assert property (@(posedge ref_clk) disable iff (!nrst)
		go_start |=> shift_data_reg[7:1] == $past(slave_addr) && st == ST_START_HOLD)
		else $error("address not loaded at start");

	a_dir_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
		go_start |=> shift_data_reg[0] == $past(transfer_direction_bit) && is_tx)
		else $error("direction bit not after address");

	a_shift_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st == ST_BYTE && scl_fall && !fresh && bit_cnt < `I2C_ACK_BIT && !release_wait)
		|=> shift_data_reg == {$past(shift_data_reg[6:0]), $past(rx_bit)})
		else $error("shift missing on falling edge");

	a_msb_first: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st == ST_BYTE && scl_fall && !fresh && is_tx && bit_cnt < `I2C_LAST_DATA_BIT)
		|=> sda_oe == !$past(shift_data_reg[6]))
		else $error("output latch not next bit");

	a_sample_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st == ST_BYTE && scl_rise) |=> rx_bit == $past(sda_s))
		else $error("sda not sampled on rising edge");

	a_slave_release: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st == ST_HOLD_WAIT && !is_master && !stop_det && wr_stb &&
		wr_data == `I2C_RELEASE_BYTE) |=> st == ST_BYTE && !scl_oe && !sda_oe ##3 !in_wait)
		else $error("slave wait not released");

	a_master_release: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st == ST_HOLD_WAIT && is_master && !is_tx && !stop_req && wait_release_bit)
		|=> st == ST_BYTE && !sda_oe && bit_cnt == 4'h0)
		else $error("master wait not released");

	a_wait_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st == ST_BYTE && scl_fall && !fresh && bit_cnt == `I2C_ACK_BIT && wait_sel9)
		|=> (st == ST_HOLD_WAIT && scl_oe) [*2])
		else $error("scl not held after ninth clock");

endmodule

/* File: verification/i2c_remote_slave.sv */
// Remote I2C slave model on the bus wires
`timescale 1ns/1ps
module i2c_remote_slave #(parameter logic [6:0] ADDR = 7'h5A) (
	// Bus wires
	input wire logic scl,
	input wire logic sda,
	output logic sda_pull,
	// Bench side
	input wire logic [7:0] tx_byte,
	output logic [7:0] addr_byte,
	output logic [7:0] rx_byte
);
	int bitn = 0;
	logic sel = 0;
	logic rd = 0;
	logic aph = 1;
	logic [7:0] sh = 8'h00;
	initial sda_pull = 0;
	// Start or stop resets the frame
	always @(sda) begin
		if (scl === 1'b1) begin
			bitn = 0;
			aph = 1;
			sel = 0;
			sda_pull = 0;
		end
	end
	// Sample on rise, address then direction
	always @(posedge scl) begin
		if (bitn < 8)
			sh = {sh[6:0], sda};
		if (bitn == 7 && aph) begin
			addr_byte = sh;
			sel = (sh[7:1] == ADDR);
			rd = sh[0];
		end else if (bitn == 7)
			rx_byte = sh;
		if (bitn == 8)
			aph = 0;
		bitn = (bitn == 8) ? 0 : bitn + 1;
	end
	// Ack, or read data MSB first, after each fall
	always @(negedge scl) begin
		if (bitn == 8)
			sda_pull = sel && (aph || !rd);
		else
			sda_pull = sel && rd && !aph && !tx_byte[7 - bitn];
	end
endmodule

/* File: verification/tb.sv */
// Bench for the I2C transfer engine as bus master
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
	logic ref_clk = 0, nrst = 0, start_req = 0, stop_req = 0, wr_stb = 0;
	logic wait_release_bit = 0, dir = 0, sda_oe, scl_oe, pull;
	logic [7:0] wr_data = 8'h00, tx = 8'h00, sdr, p_addr, p_rx;
	logic byte_done, in_wait, busy;
	logic ack_seen, is_tx, is_master, scl_out, sda_out, ack_en = 0;
	wire scl = ~scl_oe;
	wire sda = ~(sda_oe | pull);
	int err_count = 0;
	int tests_run = 0;
	// ----------------------------------------
	// Clock, design and partner
	// ----------------------------------------
	initial forever #2.5 ref_clk = ~ref_clk;
	i2c_xfer_timing uut (.ref_clk(ref_clk), .nrst(nrst), .master_en(1'b1), .wait_sel9(1'b1),
		.ack_en(ack_en), .own_addr(7'h11), .slave_addr(7'h5A), .transfer_direction_bit(dir),
		.start_req(start_req), .stop_req(stop_req), .wr_stb(wr_stb), .wr_data(wr_data),
		.wait_release_bit(wait_release_bit), .shift_data_reg(sdr), .byte_done(byte_done),
		.in_wait(in_wait), .ack_seen(ack_seen), .busy(busy), .is_tx(is_tx),
		.is_master(is_master), .scl_in(scl), .sda_in(sda), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
	i2c_remote_slave pm (.scl(scl), .sda(sda), .sda_pull(pull), .tx_byte(tx),
		.addr_byte(p_addr), .rx_byte(p_rx));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task close_out;
		$display("Checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task wait_byte;
		int n;
		n = 0;
		@(posedge ref_clk);
		while (byte_done !== 1'b1 && n < 40000) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK(byte_done, 1'b1)
		repeat (3) @(posedge ref_clk);
	endtask
	task hold_check;
		`CHK(in_wait, 1'b1)
		`CHK({scl_out, sda_out}, 2'b00)
		repeat (1500) @(posedge ref_clk);
		`CHK(scl, 1'b0)
	endtask
	task release_wait(input logic load, input logic [7:0] d);
		wr_stb <= load;
		wait_release_bit <= !load;
		wr_data <= d;
		@(posedge ref_clk);
		wr_stb <= 0;
		wait_release_bit <= 0;
		repeat (3) @(posedge ref_clk);
	endtask
	task start_xfer(input logic d);
		dir <= d;
		start_req <= 1;
		@(posedge ref_clk);
		start_req <= 0;
		wait_byte;
		`CHK(p_addr, {7'h5A, d})
		`CHK(ack_seen, 1'b1)
		`CHK(is_tx, !d)
		`CHK(is_master, 1'b1)
		hold_check;
	endtask
	task stop_xfer;
		int n;
		n = 0;
		stop_req <= 1;
		@(posedge ref_clk);
		stop_req <= 0;
		while (busy !== 1'b0 && n < 6000) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK({busy, scl, sda}, 3'b011)
		`CHK(is_master, 1'b0)
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task sc_write;
		start_xfer(1'b0);
		release_wait(1'b1, 8'hC3);
		`CHK(in_wait, 1'b0)
		wait_byte;
		`CHK(p_rx, 8'hC3)
		`CHK(ack_seen, 1'b1)
		hold_check;
		stop_xfer;
	endtask
	task sc_read;
		tx <= 8'hA5;
		ack_en <= 1'b1;
		start_xfer(1'b1);
		release_wait(1'b0, 8'h00);
		`CHK(in_wait, 1'b0)
		wait_byte;
		`CHK(sdr, 8'hA5)
		`CHK(ack_seen, 1'b1)
		hold_check;
		stop_xfer;
	endtask
	initial begin
		repeat (95000) @(posedge ref_clk);
		err_count++;
		close_out;
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1;
		repeat (5) @(posedge ref_clk);
		sc_write;
		repeat (50) @(posedge ref_clk);
		sc_read;
		close_out;
	end
endmodule
